// ==== hw/tweep_top.sv ====
// two-wire eeprom target: protocol engine, page latch, write timer
`timescale 1ns/10ps
`default_nettype none
module tweep_top #(
  parameter int unsigned WR_CYCLES = tweep_pkg::WR_CYC,
  // arbitrary type code default, no real part's value
  parameter logic [3:0] TYPE_CODE = tweep_pkg::TYPE_CODE_DEF
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic device_select_bit0,
  input wire logic device_select_bit1,
  input wire logic device_select_bit2,
  output logic sda_o,
  output logic sda_oe_b,
  output logic write_busy
);
  localparam int unsigned TW = $clog2(WR_CYCLES + 1);
  localparam logic [3:0] LAST_BIT = 4'(tweep_pkg::BITS_PER_BYTE);

  logic [2:0] scl_s;
  logic [2:0] sda_s;
  logic [2:0] sel_s0;
  logic [2:0] sel_s1;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  tweep_pkg::tweep_st_t st_q;
  logic [3:0] cnt_q;
  logic [7:0] sr_q;
  logic ack_q;
  logic rw_q;
  logic [7:0] addr_q;
  logic oe_b_q;
  logic push_q;
  tweep_pkg::tweep_wr_t push_dat_q;

  logic b_iready;
  logic b_ovalid;
  logic b_oready;
  tweep_pkg::tweep_wr_t b_odat;

  logic [7:0] mem [256];
  logic [7:0] pg_dat_q [tweep_pkg::PAGE_BYTES];
  logic [tweep_pkg::PAGE_BYTES-1:0] pg_val_q;
  logic [5:0] pg_base_q;
  logic pend_q;
  logic busy_q;
  logic [TW-1:0] tmr_q;
  logic commit_go;
  logic dev_match;

  // the first stage of each synchroniser feeds only the second
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      scl_s <= 3'h7;
      sda_s <= 3'h7;
      sel_s0 <= 3'h0;
      sel_s1 <= 3'h0;
    end else begin
      scl_s <= {scl_s[1:0], scl_i};
      sda_s <= {sda_s[1:0], sda_i};
      sel_s0 <= {device_select_bit2, device_select_bit1,
                 device_select_bit0};
      sel_s1 <= sel_s0;
    end
  end

  assign scl_rise = scl_s[1] & ~scl_s[2];
  assign scl_fall = ~scl_s[1] & scl_s[2];
  assign start_det = scl_s[1] & scl_s[2] & sda_s[2] & ~sda_s[1];
  assign stop_det = scl_s[1] & scl_s[2] & ~sda_s[2] & sda_s[1];
  assign dev_match = (sr_q[7:1] == {TYPE_CODE, sel_s1});

  // protocol engine; held idle and silent while the write cycle runs
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= tweep_pkg::ST_IDLE;
      cnt_q <= 4'h0;
      sr_q <= 8'h00;
      ack_q <= 1'b0;
      rw_q <= 1'b0;
      addr_q <= 8'h00;
      oe_b_q <= 1'b1;
      push_q <= 1'b0;
      push_dat_q <= '0;
    end else begin
      push_q <= 1'b0;
      if (busy_q || commit_go) begin
        st_q <= tweep_pkg::ST_IDLE;
        oe_b_q <= 1'b1;
        ack_q <= 1'b0;
      end else if (start_det) begin
        st_q <= tweep_pkg::ST_DEV;
        cnt_q <= 4'h0;
        ack_q <= 1'b0;
        oe_b_q <= 1'b1;
      end else if (stop_det) begin
        st_q <= tweep_pkg::ST_IDLE;
        ack_q <= 1'b0;
        oe_b_q <= 1'b1;
      end else begin
        case (st_q)
          tweep_pkg::ST_IDLE: begin
            oe_b_q <= 1'b1;
          end
          tweep_pkg::ST_DEV, tweep_pkg::ST_WORD,
          tweep_pkg::ST_DATA: begin
            if (scl_rise && !ack_q) begin
              sr_q <= {sr_q[6:0], sda_s[1]};
              cnt_q <= cnt_q + 4'h1;
            end else if (scl_fall && ack_q) begin
              // ninth clock done: release and move on
              oe_b_q <= 1'b1;
              ack_q <= 1'b0;
              cnt_q <= 4'h0;
              if (st_q == tweep_pkg::ST_DEV &&
                  rw_q == tweep_pkg::DIR_READ) begin
                st_q <= tweep_pkg::ST_TX;
                sr_q <= mem[addr_q];
                oe_b_q <= mem[addr_q][7];
                addr_q <= addr_q + 8'h01;
              end else if (st_q == tweep_pkg::ST_DEV) begin
                st_q <= tweep_pkg::ST_WORD;
              end else begin
                st_q <= tweep_pkg::ST_DATA;
              end
            end else if (scl_fall && cnt_q == LAST_BIT) begin
              case (st_q)
                tweep_pkg::ST_DEV: begin
                  if (dev_match) begin
                    ack_q <= 1'b1;
                    oe_b_q <= 1'b0;
                    rw_q <= sr_q[0];
                  end else begin
                    st_q <= tweep_pkg::ST_IDLE;
                  end
                end
                tweep_pkg::ST_WORD: begin
                  ack_q <= 1'b1;
                  oe_b_q <= 1'b0;
                  addr_q <= sr_q;
                end
                default: begin
                  // a full buffer withholds the acknowledge
                  if (b_iready) begin
                    ack_q <= 1'b1;
                    oe_b_q <= 1'b0;
                    push_q <= 1'b1;
                    push_dat_q <= '{addr: addr_q, data: sr_q};
                    addr_q[1:0] <= addr_q[1:0] + 2'h1;
                  end else begin
                    st_q <= tweep_pkg::ST_IDLE;
                  end
                end
              endcase
            end
          end
          tweep_pkg::ST_TX: begin
            if (scl_rise) begin
              cnt_q <= cnt_q + 4'h1;
            end else if (scl_fall) begin
              if (cnt_q == LAST_BIT) begin
                oe_b_q <= 1'b1;
                st_q <= tweep_pkg::ST_RACK;
              end else begin
                sr_q <= {sr_q[6:0], 1'b0};
                oe_b_q <= sr_q[6];
              end
            end
          end
          tweep_pkg::ST_RACK: begin
            if (scl_rise) begin
              if (sda_s[1]) begin
                st_q <= tweep_pkg::ST_IDLE;
              end else begin
                st_q <= tweep_pkg::ST_NEXT;
              end
            end
          end
          tweep_pkg::ST_NEXT: begin
            if (scl_fall) begin
              st_q <= tweep_pkg::ST_TX;
              cnt_q <= 4'h0;
              sr_q <= mem[addr_q];
              oe_b_q <= mem[addr_q][7];
              addr_q <= addr_q + 8'h01;
            end
          end
          default: begin
            st_q <= tweep_pkg::ST_IDLE;
          end
        endcase
      end
    end
  end

  tweep_buf2 #(
    .WIDTH($bits(tweep_pkg::tweep_wr_t))
  ) u_buf (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .in_valid(push_q),
    .in_ready(b_iready),
    .in_data(push_dat_q),
    .out_valid(b_ovalid),
    .out_ready(b_oready),
    .out_data(b_odat)
  );

  // page loading pauses while the array is being programmed
  assign b_oready = ~busy_q;
  assign commit_go = pend_q & ~b_ovalid & ~busy_q;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pg_val_q <= '0;
      pg_base_q <= 6'h00;
      pend_q <= 1'b0;
    end else begin
      if (stop_det && !busy_q && st_q == tweep_pkg::ST_DATA) begin
        pend_q <= 1'b1;
      end else if (commit_go) begin
        pend_q <= 1'b0;
      end
      if (commit_go) begin
        pg_val_q <= '0;
      end else if (b_ovalid && b_oready) begin
        pg_val_q[b_odat.addr[1:0]] <= 1'b1;
        pg_base_q <= b_odat.addr[7:2];
      end else if (start_det && !pend_q && !busy_q) begin
        pg_val_q <= '0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (b_ovalid && b_oready) begin
      pg_dat_q[b_odat.addr[1:0]] <= b_odat.data;
    end
  end

  // all loaded slots land in the array at once when programming starts
  always_ff @(posedge sys_clk) begin
    if (commit_go) begin
      for (int i = 0; i < tweep_pkg::PAGE_BYTES; i++) begin
        if (pg_val_q[i]) begin
          mem[{pg_base_q, 2'(i)}] <= pg_dat_q[i];
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      busy_q <= 1'b0;
      tmr_q <= '0;
    end else if (commit_go && |pg_val_q) begin
      busy_q <= 1'b1;
      tmr_q <= TW'(WR_CYCLES - 1);
    end else if (busy_q) begin
      if (tmr_q == '0) begin
        busy_q <= 1'b0;
      end else begin
        tmr_q <= tmr_q - TW'(1);
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sda_o <= 1'b0;
      sda_oe_b <= 1'b1;
      write_busy <= 1'b0;
    end else begin
      sda_o <= 1'b0;
      sda_oe_b <= oe_b_q;
      write_busy <= busy_q;
    end
  end
endmodule
`default_nettype wire

// ==== hw/tweep_pkg.sv ====
// constants and types shared by the two-wire eeprom target logic
// Contract
// - accept page write of up to four bytes
// - acknowledge every received data byte
// - data byte bumps only two low address bits
// - fifth byte wraps onto earlier page slots
// - stop after write starts cycle, bus ignored
// - no address acknowledge while write cycle runs
// - read direction bit is one
// - counter holds last accessed location plus one
// - acknowledge read address, then shift eight bits
// - random read returns byte at loaded address
// - one further byte per controller acknowledge
// - read counter wraps 255 to 0
// - acknowledge only matching type code and selects
// - word address acknowledged and loads counter
// - missing acknowledge releases line until start
// - write cycle lasts at most 10 ms
`default_nettype none
package tweep_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned PAGE_BYTES = 4;
  localparam int unsigned PAGE_W = 2;
  localparam int unsigned BITS_PER_BYTE = 8;
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned T_WR_MS = 10;
  // longest time: rounds down, i.e. exact product here
  localparam int unsigned WR_CYC = T_WR_MS * 1000 * CLK_MHZ;
  // arbitrary neutral type code, not a real part's
  localparam logic [3:0] TYPE_CODE_DEF = 4'h5;
  localparam logic DIR_READ = 1'b1;
  localparam int unsigned BUF_DEPTH = 2;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } tweep_wr_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DEV,
    ST_WORD,
    ST_DATA,
    ST_TX,
    ST_RACK,
    ST_NEXT
  } tweep_st_t;
endpackage
`default_nettype wire

// ==== hw/tweep_buf2.sv ====
// two-entry valid/ready buffer for received write bytes
`timescale 1ns/10ps
`default_nettype none
module tweep_buf2 #(
  parameter int unsigned WIDTH = 16
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  logic [WIDTH-1:0] mem_q [2];
  logic wp_q;
  logic rp_q;
  logic [1:0] cnt_q;
  logic do_in;
  logic do_out;

  assign in_ready = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign out_data = mem_q[rp_q];
  assign do_in = in_valid & in_ready;
  assign do_out = out_valid & out_ready;

  always_ff @(posedge sys_clk) begin
    if (do_in) begin
      mem_q[wp_q] <= in_data;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wp_q <= 1'b0;
      rp_q <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      if (do_in) begin
        wp_q <= ~wp_q;
      end
      if (do_out) begin
        rp_q <= ~rp_q;
      end
      cnt_q <= cnt_q + {1'b0, do_in} - {1'b0, do_out};
    end
  end
endmodule
`default_nettype wire

// ==== sim/tweep_monitor.sv ====
// pin-level checks on the eeprom target, bound into tweep_top
`timescale 1ns/10ps
`default_nettype none
module tweep_monitor #(
  parameter int unsigned WR_CYCLES = tweep_pkg::WR_CYC,
  parameter logic [3:0] TYPE_CODE = tweep_pkg::TYPE_CODE_DEF
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic device_select_bit0,
  input wire logic device_select_bit1,
  input wire logic device_select_bit2,
  input wire logic sda_o,
  input wire logic sda_oe_b,
  input wire logic write_busy
);
  logic [31:0] bcnt_q;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      bcnt_q <= 32'h0;
    end else begin
      bcnt_q <= write_busy ? bcnt_q + 32'h1 : 32'h0;
    end
  end
  // shadow of the first byte after each start, for the select check
  logic scl_p_q;
  logic sda_p_q;
  logic [7:0] sh_q;
  logic [3:0] nb_q;
  logic first_q;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
      sh_q <= 8'h00;
      nb_q <= 4'h0;
      first_q <= 1'b0;
    end else begin
      scl_p_q <= scl_i;
      sda_p_q <= sda_i;
      if (scl_i && scl_p_q && sda_p_q && !sda_i) begin
        nb_q <= 4'h0;
        first_q <= 1'b1;
      end else if (scl_i && !scl_p_q && first_q) begin
        if (nb_q == 4'h8) begin
          first_q <= 1'b0;
        end else begin
          sh_q <= {sh_q[6:0], sda_i};
          nb_q <= nb_q + 4'h1;
        end
      end
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  property p_odrain; sda_o == 1'b0; endproperty
  a_odrain: assert property (p_odrain)
    else $error("data pin not pulled low");
  property p_busy_len; $fell(write_busy) |-> bcnt_q == WR_CYCLES; endproperty
  a_busy_len: assert property (p_busy_len)
    else $error("write cycle length off");
  property p_busy_max; bcnt_q <= WR_CYCLES; endproperty
  a_busy_max: assert property (p_busy_max)
    else $error("write cycle too long");
  property p_busy_quiet; write_busy |-> sda_oe_b; endproperty
  a_busy_quiet: assert property (p_busy_quiet)
    else $error("line driven while busy");
  property p_busy_stop; $rose(write_busy) |-> scl_i && sda_i; endproperty
  a_busy_stop: assert property (p_busy_stop)
    else $error("write cycle without stop");
  property p_busy_hold; $rose(write_busy) |=> write_busy [*8]; endproperty
  a_busy_hold: assert property (p_busy_hold)
    else $error("write cycle cut short");
  // the driver may move only a few clocks after the clock pin fell
  property p_oe_edge;
    $changed(sda_oe_b) |-> !$past(scl_i, 2) && $past(scl_i, 6);
  endproperty
  a_oe_edge: assert property (p_oe_edge)
    else $error("data line moved outside clock low");
  property p_oe_low; $fell(sda_oe_b) |=> !sda_oe_b [*8]; endproperty
  a_oe_low: assert property (p_oe_low)
    else $error("low drive too short");
  property p_sel_match;
    $fell(sda_oe_b) && first_q && nb_q == 4'h8 |->
      sh_q[7:1] == {TYPE_CODE, device_select_bit2, device_select_bit1,
                    device_select_bit0};
  endproperty
  a_sel_match: assert property (p_sel_match)
    else $error("address acknowledged without a match");
  c_busy: cover property ($rose(write_busy));
  c_drive: cover property ($fell(sda_oe_b) && !write_busy);
  c_done: cover property ($fell(write_busy));
endmodule
bind tweep_top tweep_monitor #(
  .WR_CYCLES(WR_CYCLES),
  .TYPE_CODE(TYPE_CODE)
) mon (
  .sys_clk(sys_clk),
  .rst_b(rst_b),
  .scl_i(scl_i),
  .sda_i(sda_i),
  .device_select_bit0(device_select_bit0),
  .device_select_bit1(device_select_bit1),
  .device_select_bit2(device_select_bit2),
  .sda_o(sda_o),
  .sda_oe_b(sda_oe_b),
  .write_busy(write_busy)
);
`default_nettype wire

// ==== sim/tweep_ctl_model.sv ====
// behavioural two-wire bus controller facing the eeprom target
`timescale 1ns/10ps
`default_nettype none
module tweep_ctl_model (
  output logic scl,
  output logic sda_drv,
  input wire logic sda
);
  // clock stands high between frames; one bit takes 160 ns
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic bit_x(input logic b, output logic r);
    sda_drv = b;
    #40 scl = 1'b1;
    #40 r = sda;
    #40 scl = 1'b0;
    #40;
  endtask
  task automatic start();
    sda_drv = 1'b1;
    #40 scl = 1'b1;
    #40 sda_drv = 1'b0;
    #40 scl = 1'b0;
    #40;
  endtask
  task automatic stop();
    sda_drv = 1'b0;
    #40 scl = 1'b1;
    #40 sda_drv = 1'b1;
    #40;
  endtask
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(d[i], r);
    bit_x(1'b1, r);
    ack = !r;
  endtask
  task automatic rd_byte(input logic ack_in, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, r);
      d[i] = r;
    end
    // a last byte leaves the line high on the ninth clock
    bit_x(!ack_in, r);
  endtask
endmodule
`default_nettype wire

// ==== sim/test_two_wire_eeprom_page_write_read.sv ====
// self-checking bench: page write, polling, reads, select straps
`timescale 1ns/10ps
`default_nettype none
module test_two_wire_eeprom_page_write_read;
  localparam int unsigned WR = 2000;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [2:0] sel = 3'h5;
  logic sda_o, sda_oe_b, write_busy, scl, ctl_sda, bp;
  logic [15:0] blen = 16'h0;
  wire logic sda;
  int miscompares = 0;
  int n_checks = 0;
  // pulled up unless a party drives it low
  assign sda = ctl_sda & (sda_oe_b | sda_o);
  initial forever #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    blen <= (write_busy && !bp) ? 16'h1 : blen + {15'h0, write_busy};
    bp <= write_busy;
  end
  tweep_ctl_model ctl (
    .scl(scl),
    .sda_drv(ctl_sda),
    .sda(sda)
  );
  tweep_top #(
    .WR_CYCLES(WR)
  ) dut (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .scl_i(scl),
    .sda_i(sda),
    .device_select_bit0(sel[0]),
    .device_select_bit1(sel[1]),
    .device_select_bit2(sel[2]),
    .sda_o(sda_o),
    .sda_oe_b(sda_oe_b),
    .write_busy(write_busy)
  );
  task automatic chk(input string what, input logic [15:0] e, s);
    n_checks++;
    if (s !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, e, s);
    end
  endtask
  task automatic addr(input logic rw, output logic k);
    ctl.start();
    ctl.wr_byte({tweep_pkg::TYPE_CODE_DEF, sel, rw}, k);
  endtask
  task automatic wr_page(input logic [7:0] a, input logic [7:0] d[$]);
    logic k;
    addr(1'b0, k);
    chk("addr ack", 1'b1, k);
    ctl.wr_byte(a, k);
    chk("word ack", 1'b1, k);
    foreach (d[i]) begin
      ctl.wr_byte(d[i], k);
      chk("data ack", 1'b1, k);
    end
    ctl.stop();
  endtask
  task automatic poll();
    logic k;
    int n;
    n = 0;
    k = 1'b0;
    while (!k && n < 40) begin
      addr(1'b0, k);
      n++;
    end
    ctl.stop();
    chk("poll ack", 1'b1, k);
    chk("poll nacked", 1'b1, n > 1);
    chk("busy length", 16'(WR), blen);
  endtask
  task automatic rd(input logic rnd, input logic [7:0] a,
                    input logic [7:0] e[$]);
    logic k;
    logic [7:0] v;
    if (rnd) begin
      addr(1'b0, k);
      ctl.wr_byte(a, k);
      chk("dummy ack", 1'b1, k);
    end
    addr(1'b1, k);
    chk("read ack", 1'b1, k);
    for (int i = 0; i < e.size(); i++) begin
      ctl.rd_byte(i < e.size() - 1, v);
      chk("read data", e[i], v);
    end
    ctl.stop();
  endtask
  task automatic t_page();
    logic k;
    wr_page(8'h45, '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55});
    addr(1'b1, k);
    chk("busy nack", 1'b0, k);
    ctl.stop();
    poll();
    rd(1'b0, 8'h00, '{8'h22});
    rd(1'b1, 8'h44, '{8'h44, 8'h55, 8'h22, 8'h33});
    $display("page test done");
  endtask
  task automatic t_wrap();
    wr_page(8'h00, '{8'h5A});
    poll();
    wr_page(8'hFE, '{8'hC1, 8'hC2});
    poll();
    rd(1'b1, 8'hFE, '{8'hC1, 8'hC2, 8'h5A});
    rd(1'b1, 8'hFF, '{8'hC2});
    rd(1'b0, 8'h00, '{8'h5A});
    $display("wrap test done");
  endtask
  task automatic t_select();
    logic k;
    for (int s = 0; s < 8; s += 3) begin
      sel = 3'(s);
      #100;
      addr(1'b0, k);
      chk("sel ack", 1'b1, k);
      ctl.start();
      ctl.wr_byte({tweep_pkg::TYPE_CODE_DEF, ~sel, 1'b0}, k);
      chk("sel nack", 1'b0, k);
      ctl.start();
      ctl.wr_byte({tweep_pkg::TYPE_CODE_DEF ^ 4'h3, sel, 1'b0}, k);
      chk("type nack", 1'b0, k);
      ctl.stop();
    end
    $display("select test done");
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge sys_clk);
    #1 rst_b = 1'b1;
    repeat (4) @(posedge sys_clk);
    #1;
    chk("oe idle", 1'b1, sda_oe_b);
    t_page();
    t_wrap();
    t_select();
    give_verdict();
  end
  initial begin
    #300000;
    miscompares++;
    give_verdict();
  end
endmodule
`default_nettype wire
